// File: rtl/emd_accum.sv
// Six presettable energy accumulators
`timescale 1ns/10ps
`include "emd_consts.svh"

module emd_accum (
    input  wire logic               core_clk,
    input  wire logic               nrst,
    input  wire logic               tick,
    input  wire logic signed [31:0] samp_p,
    input  wire logic signed [31:0] samp_q,
    input  wire logic signed [31:0] samp_s,
    input  wire logic               pre_wr,
    input  wire logic               pre_hi,
    input  wire logic [2:0]         pre_idx,
    input  wire logic [31:0]        pre_data,
    output logic [5:0][63:0]        acc
);
    logic [31:0]             stage_r;
    logic signed [2:0][31:0] smp;
    logic                    over;

    function automatic logic [63:0] clip(input logic [64:0] v);
        return (v > {1'b0, `EMD_E_MAX}) ? `EMD_E_MAX : v[63:0];
    endfunction

    function automatic logic [63:0] mag(input logic signed [31:0] x);
        logic [31:0] m;
        m = x[31] ? 32'(-x) : 32'(x);
        return {32'h0, m};
    endfunction

    assign smp = {samp_s, samp_q, samp_p};

    // ----------------------------------------
    // Low word staging
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            stage_r <= 32'h0;
        end else if (pre_wr && !pre_hi) begin
            stage_r <= pre_data;
        end
    end

    // ----------------------------------------
    // Accumulate and preset
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            acc <= '0;
        end else begin
            for (int i = 0; i < `EMD_ACC_N; i++) begin
                if (pre_wr && pre_hi && pre_idx == 3'(i)) begin
                    acc[i] <= clip({1'b0, pre_data, stage_r});
                end else if (tick && ((i / 2 == 2 ? samp_p[31] : smp[i / 2][31]) == i[0])) begin
                    acc[i] <= clip({1'b0, acc[i]} + {1'b0, mag(smp[i / 2])});
                end
            end
        end
    end

    always_comb begin
        over = 1'b0;
        for (int i = 0; i < `EMD_ACC_N; i++) begin
            over = over | (acc[i] > `EMD_E_MAX);
        end
    end

    AST_ACC_LIMIT: assert property (@(posedge core_clk) disable iff (!nrst) !over)
        else $error("Energy accumulator above overflow limit");
    AST_PRESET: assert property (@(posedge core_clk) disable iff (!nrst)
        (pre_wr && pre_hi && pre_idx == 3'h0 && pre_data[31] == 1'b0)
        |=> acc[0] == {$past(pre_data), $past(stage_r)})
        else $error("Preset value not loaded");
endmodule

// File: rtl/emd_consts.svh
// Offsets, fields, reset values and timing counts of the demand block
`ifndef EMD_CONSTS_SVH
`define EMD_CONSTS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define EMD_CLK_NS   20
`define EMD_SEC_NS   1000000000
`define EMD_SEC_CYC  (`EMD_SEC_NS / `EMD_CLK_NS)
`define EMD_CYC50    6'h32
`define EMD_CYC60    6'h3c
`define EMD_SLD_FAST 16'h000f
`define EMD_SLD_SLOW 16'h003c
`define EMD_SLD_LIM  6'h0f
`define EMD_MIN_S    16'h003c
`define EMD_IVAL_MAX 6'h3c
`define EMD_DAY_MIN  12'h5a0
`define EMD_TH_K     11'h01a
`define EMD_E_MAX    64'h7fff_ffff_ffff_ffff

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define EMD_R_CTRL  8'h00
`define EMD_R_SYNC  8'h04
`define EMD_R_CMD   8'h08
`define EMD_R_SCHED 8'h0c
`define EMD_R_UWT   8'h10
`define EMD_R_PRES  8'h14
`define EMD_R_LAST  8'h18
`define EMD_R_PRED  8'h1c
`define EMD_R_PEAK  8'h20
`define EMD_R_PTIME 8'h24
`define EMD_R_MIN   8'h28
`define EMD_R_MAX   8'h2c
`define EMD_R_STAT  8'h30
`define EMD_R_LOG   8'h34
`define EMD_ACC_PG  2'h1
`define EMD_ACC_N   6

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define EMD_CTRL_MODE 0
`define EMD_CTRL_IVAL 8
`define EMD_CTRL_SUB  16
`define EMD_CTRL_SRC  24
`define EMD_CTRL_F60  28
`define EMD_CMD_SYNC  0
`define EMD_CMD_PCLR  1
`define EMD_CMD_PASS  16
`define EMD_SCHED_EN  31
`define EMD_CTRL_RST  32'h0005_0f00
`define EMD_MIN_RST   32'h7fff_ffff
`define EMD_MAX_RST   32'h8000_0000

`endif

// File: rtl/emd_demand.sv
// Demand calculator with min/max, peak and preset energy
`timescale 1ns/10ps
`include "emd_consts.svh"

module emd_demand #(
    parameter int unsigned SEC_CYCLES = `EMD_SEC_CYC,
    parameter int unsigned DEPTH      = 60,
    parameter logic [15:0] PASSCODE   = 16'h0000
) (
    input  wire logic               core_clk,
    input  wire logic               nrst,
    input  wire logic [7:0]         addr,
    input  wire logic [31:0]        wr_data,
    input  wire logic               wr_en,
    input  wire logic               rd_en,
    output logic [31:0]             rd_data,
    input  wire logic signed [31:0] samp_p,
    input  wire logic signed [31:0] samp_q,
    input  wire logic signed [31:0] samp_s,
    input  wire logic signed [31:0] samp_i,
    input  wire logic               util_pulse,
    input  wire logic               line_cyc,
    input  wire logic               sync_in,
    input  wire logic [10:0]        rtc_min,
    input  wire logic               rtc_min_tick,
    input  wire logic [31:0]        rtc_stamp,
    output logic                    dmd_end,
    output logic                    refresh,
    output logic                    mm_save,
    output logic                    peak_log
);
    logic [31:0] ctrl_r, sched_r, uwt_r, log_r, rd_data_r;
    logic [10:0] sync_r;
    logic [31:0] pres_r, last_r, pred_r, peak_r, ptime_r, min_r, max_r;
    logic [31:0] div_r, uacc_r, usec_r;
    logic        tick_r, sync_q_r, pub_r, refresh_r, mm_save_r, peak_log_r;
    logic [5:0]  lcnt_r;
    logic [47:0] run_r, therm_r;
    logic [15:0] rsec_r;
    logic [7:0]  fill_r;
    logic [47:0] ring_s [DEPTH];
    logic [15:0] ring_t [DEPTH];
    logic [5:0][63:0] acc;

    emd_pkg::emd_mode_t mode;
    emd_pkg::emd_sync_t syn;
    logic [5:0]  ival, sub, step;
    logic [7:0]  nbk;
    logic [15:0] blen, bsec, wsec, rem;
    logic [47:0] bsum, wsum, add;
    logic [31:0] dmd_new, sel;
    logic signed [31:0] reading;
    logic [11:0] cmod;
    logic [4:0]  tk;
    logic [48:0] tdiff;
    logic        roll, sub_ok, bend, pub_ok, cfg_wr, cmd_wr, pre_wr;
    logic        pclr_man, pclr, line_done;

    function automatic logic [31:0] udiv(input logic [47:0] n, input logic [15:0] d);
        return (d == 16'h0) ? 32'h0 : 32'(n / {32'h0, d});
    endfunction

    function automatic logic [4:0] tshift(input logic [5:0] n);
        logic [10:0] p;
        logic [4:0]  k;
        p = 11'(n) * `EMD_TH_K;
        k = 5'h0;
        for (int i = 0; i < 11; i++) begin
            if (p[i]) k = 5'(i);
        end
        return k;
    endfunction

    // ----------------------------------------
    // Configuration decode
    // ----------------------------------------
    always_comb begin
        mode = emd_pkg::emd_mode_t'(ctrl_r[`EMD_CTRL_MODE +: 4]);
        ival = ctrl_r[`EMD_CTRL_IVAL +: 6];
        if (ival == 6'h0) ival = 6'h01;
        if (ival > `EMD_IVAL_MAX) ival = `EMD_IVAL_MAX;
        sub = ctrl_r[`EMD_CTRL_SUB +: 6];
        sub_ok = (sub != 6'h0) && (ival % sub == 6'h0);
        if (!sub_ok) sub = ival;
        roll = 1'b0;
        syn = emd_pkg::EMD_SYN_TIMER;
        blen = 16'(ival) * `EMD_MIN_S;
        nbk = 8'h01;
        case (mode)
            emd_pkg::EMD_SLIDE: begin
                if (ival <= `EMD_SLD_LIM) begin
                    blen = `EMD_SLD_FAST;
                    nbk = 8'(ival) * 8'h04;
                end else begin
                    blen = `EMD_SLD_SLOW;
                    nbk = 8'(ival);
                end
            end
            emd_pkg::EMD_ROLL: roll = 1'b1;
            emd_pkg::EMD_IN_BLK: syn = emd_pkg::EMD_SYN_INPUT;
            emd_pkg::EMD_IN_ROLL: begin
                syn = emd_pkg::EMD_SYN_INPUT;
                roll = 1'b1;
            end
            emd_pkg::EMD_CMD_BLK: syn = emd_pkg::EMD_SYN_CMD;
            emd_pkg::EMD_CMD_ROLL: begin
                syn = emd_pkg::EMD_SYN_CMD;
                roll = 1'b1;
            end
            emd_pkg::EMD_CLK_BLK: syn = emd_pkg::EMD_SYN_CLOCK;
            emd_pkg::EMD_CLK_ROLL: begin
                syn = emd_pkg::EMD_SYN_CLOCK;
                roll = 1'b1;
            end
            default: ;
        endcase
        if (roll) begin
            blen = 16'(sub) * `EMD_MIN_S;
            nbk = 8'(ival / sub);
        end
        step = roll ? sub : ival;
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always_comb begin
        cfg_wr = 1'b0;
        cmd_wr = 1'b0;
        pre_wr = 1'b0;
        if (!wr_en) begin
            cfg_wr = 1'b0;
        end else if (addr == `EMD_R_CTRL) begin
            cfg_wr = 1'b1;
        end else if (addr == `EMD_R_CMD) begin
            cmd_wr = 1'b1;
        end else if (addr[7:6] == `EMD_ACC_PG && addr[5:3] < 3'(`EMD_ACC_N)) begin
            pre_wr = 1'b1;
        end
        pclr_man = cmd_wr && wr_data[`EMD_CMD_PCLR] &&
                   wr_data[`EMD_CMD_PASS +: 16] == PASSCODE;
        pclr = pclr_man || (sched_r[`EMD_SCHED_EN] && rtc_min_tick &&
                            rtc_min == sched_r[10:0]);
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= `EMD_CTRL_RST;
            sync_r <= 11'h0;
            sched_r <= 32'h0;
            uwt_r <= 32'h0000_0001;
        end else if (wr_en) begin
            if (addr == `EMD_R_CTRL) begin
                ctrl_r <= wr_data;
            end else if (addr == `EMD_R_SYNC) begin
                sync_r <= wr_data[10:0];
            end else if (addr == `EMD_R_SCHED) begin
                sched_r <= wr_data;
            end else if (addr == `EMD_R_UWT) begin
                uwt_r <= wr_data;
            end
        end
    end

    // ----------------------------------------
    // Second divider and source select
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            div_r <= 32'h0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= (div_r == 32'(SEC_CYCLES - 1));
            div_r <= (div_r == 32'(SEC_CYCLES - 1)) ? 32'h0 : div_r + 32'h1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            uacc_r <= 32'h0;
            usec_r <= 32'h0;
        end else if (tick_r) begin
            usec_r <= uacc_r + (util_pulse ? uwt_r : 32'h0);
            uacc_r <= 32'h0;
        end else if (util_pulse) begin
            uacc_r <= uacc_r + uwt_r;
        end
    end

    always_comb begin
        case (emd_pkg::emd_src_t'(ctrl_r[`EMD_CTRL_SRC +: 3]))
            emd_pkg::EMD_SRC_Q: reading = samp_q;
            emd_pkg::EMD_SRC_S: reading = samp_s;
            emd_pkg::EMD_SRC_I: reading = samp_i;
            emd_pkg::EMD_SRC_UTIL: reading = $signed(usec_r);
            default: reading = samp_p;
        endcase
        sel = reading[31] ? 32'h0 : 32'(reading);
    end

    // ----------------------------------------
    // Interval boundaries
    // ----------------------------------------
    always_comb begin
        add = tick_r ? {16'h0, sel} : 48'h0;
        bsum = run_r + add;
        bsec = (rsec_r == 16'hffff) ? rsec_r : rsec_r + 16'(tick_r);
        cmod = (12'(rtc_min) + `EMD_DAY_MIN - 12'(sync_r)) % 12'(step);
        case (syn)
            emd_pkg::EMD_SYN_INPUT: bend = sync_in && !sync_q_r;
            emd_pkg::EMD_SYN_CMD: bend = cmd_wr && wr_data[`EMD_CMD_SYNC];
            emd_pkg::EMD_SYN_CLOCK: bend = rtc_min_tick && cmod == 12'h0;
            default: bend = tick_r && bsec >= blen;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sync_q_r <= 1'b0;
            pub_r <= 1'b0;
            run_r <= 48'h0;
            rsec_r <= 16'h0;
            fill_r <= 8'h0;
        end else begin
            sync_q_r <= sync_in;
            pub_r <= bend && !cfg_wr;
            if (cfg_wr) begin
                run_r <= 48'h0;
                rsec_r <= 16'h0;
                fill_r <= 8'h0;
            end else if (bend) begin
                run_r <= 48'h0;
                rsec_r <= 16'h0;
                fill_r <= (fill_r == 8'(DEPTH)) ? fill_r : fill_r + 8'h01;
            end else begin
                run_r <= bsum;
                rsec_r <= bsec;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (bend) begin
            for (int i = DEPTH - 1; i > 0; i--) begin
                ring_s[i] <= ring_s[i - 1];
                ring_t[i] <= ring_t[i - 1];
            end
            ring_s[0] <= bsum;
            ring_t[0] <= bsec;
        end
    end

    always_comb begin
        wsum = 48'h0;
        wsec = 16'h0;
        for (int i = 0; i < DEPTH; i++) begin
            if (8'(i) < nbk) begin
                wsum = wsum + ring_s[i];
                wsec = wsec + ring_t[i];
            end
        end
        tk = tshift(ival);
        tdiff = {1'b0, sel, 16'h0} - {1'b0, therm_r};
        pub_ok = pub_r && fill_r >= nbk;
        dmd_new = (mode == emd_pkg::EMD_THERM) ? therm_r[47:16] : udiv(wsum, wsec);
        rem = (blen > bsec) ? blen - bsec : 16'h0;
    end

    // ----------------------------------------
    // Demand values
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            therm_r <= 48'h0;
            pres_r <= 32'h0;
            pred_r <= 32'h0;
            last_r <= 32'h0;
        end else begin
            if (tick_r) begin
                therm_r <= 48'($signed({1'b0, therm_r}) + ($signed(tdiff) >>> tk));
                pres_r <= udiv(bsum, bsec);
                pred_r <= udiv(bsum + 48'(sel) * 48'(rem), blen);
            end
            if (pub_ok) begin
                last_r <= dmd_new;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            peak_r <= 32'h0;
            ptime_r <= 32'h0;
            log_r <= 32'h0;
            peak_log_r <= 1'b0;
        end else begin
            peak_log_r <= pclr;
            if (pclr) log_r <= peak_r;
            if (pub_ok && dmd_new > (pclr ? 32'h0 : peak_r)) begin
                peak_r <= dmd_new;
                ptime_r <= rtc_stamp;
            end else if (pclr) begin
                peak_r <= 32'h0;
                ptime_r <= 32'h0;
            end
        end
    end

    // ----------------------------------------
    // Refresh and min/max
    // ----------------------------------------
    assign line_done = line_cyc &&
                       lcnt_r + 6'h01 >= (ctrl_r[`EMD_CTRL_F60] ? `EMD_CYC60 : `EMD_CYC50);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lcnt_r <= 6'h0;
            refresh_r <= 1'b0;
            mm_save_r <= 1'b0;
            min_r <= `EMD_MIN_RST;
            max_r <= `EMD_MAX_RST;
        end else begin
            refresh_r <= line_done;
            if (line_cyc) lcnt_r <= line_done ? 6'h0 : lcnt_r + 6'h01;
            mm_save_r <= line_done && (reading < $signed(min_r) || reading > $signed(max_r));
            if (line_done && reading < $signed(min_r)) min_r <= reading;
            if (line_done && reading > $signed(max_r)) max_r <= reading;
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data_r <= 32'h0;
        end else if (!rd_en) begin
            rd_data_r <= 32'h0;
        end else if (addr == `EMD_R_CTRL) begin
            rd_data_r <= ctrl_r;
        end else if (addr == `EMD_R_SYNC) begin
            rd_data_r <= {21'h0, sync_r};
        end else if (addr == `EMD_R_SCHED) begin
            rd_data_r <= sched_r;
        end else if (addr == `EMD_R_UWT) begin
            rd_data_r <= uwt_r;
        end else if (addr == `EMD_R_PRES) begin
            rd_data_r <= pres_r;
        end else if (addr == `EMD_R_LAST) begin
            rd_data_r <= last_r;
        end else if (addr == `EMD_R_PRED) begin
            rd_data_r <= pred_r;
        end else if (addr == `EMD_R_PEAK) begin
            rd_data_r <= peak_r;
        end else if (addr == `EMD_R_PTIME) begin
            rd_data_r <= ptime_r;
        end else if (addr == `EMD_R_MIN) begin
            rd_data_r <= min_r;
        end else if (addr == `EMD_R_MAX) begin
            rd_data_r <= max_r;
        end else if (addr == `EMD_R_STAT) begin
            rd_data_r <= {15'h0, !sub_ok, fill_r, rsec_r[7:0]};
        end else if (addr == `EMD_R_LOG) begin
            rd_data_r <= log_r;
        end else if (addr[7:6] == `EMD_ACC_PG && addr[5:3] < 3'(`EMD_ACC_N)) begin
            rd_data_r <= addr[2] ? acc[addr[5:3]][63:32] : acc[addr[5:3]][31:0];
        end else begin
            rd_data_r <= 32'h0;
        end
    end

    emd_accum i_emd_accum (
        .core_clk (core_clk),
        .nrst     (nrst),
        .tick     (tick_r),
        .samp_p   (samp_p),
        .samp_q   (samp_q),
        .samp_s   (samp_s),
        .pre_wr   (pre_wr),
        .pre_hi   (addr[2]),
        .pre_idx  (addr[5:3]),
        .pre_data (wr_data),
        .acc      (acc)
    );

    assign rd_data = rd_data_r;
    assign dmd_end = pub_r;
    assign refresh = refresh_r;
    assign mm_save = mm_save_r;
    assign peak_log = peak_log_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_REFRESH: assert property (@(posedge core_clk) disable iff (!nrst)
        (line_cyc && lcnt_r == 6'h31 && !ctrl_r[`EMD_CTRL_F60]) |=> refresh_r)
        else $error("Refresh missing after 50 line cycles");
    AST_NO_REFRESH: assert property (@(posedge core_clk) disable iff (!nrst)
        !line_cyc |=> !refresh_r)
        else $error("Refresh without line cycle");
    AST_MIN: assert property (@(posedge core_clk) disable iff (!nrst)
        (line_done && reading < $signed(min_r)) |=> (min_r == $past(reading) && mm_save_r))
        else $error("Minimum not replaced");
    AST_SLD_RATE: assert property (@(posedge core_clk) disable iff (!nrst)
        (mode == emd_pkg::EMD_SLIDE) |-> (blen == (ival <= 6'h0f ? 16'h000f : 16'h003c)))
        else $error("Sliding update period wrong");
    AST_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
        !pub_r |=> $stable(last_r))
        else $error("Demand published off interval end");
    AST_TIMED_END: assert property (@(posedge core_clk) disable iff (!nrst)
        (syn == emd_pkg::EMD_SYN_TIMER && tick_r && bsec >= blen && !cfg_wr) |=> pub_r)
        else $error("Interval end not flagged");
    AST_CMD_SYNC: assert property (@(posedge core_clk) disable iff (!nrst)
        (syn == emd_pkg::EMD_SYN_CMD && cmd_wr && wr_data[0]) |=> (pub_r && rsec_r == 16'h0))
        else $error("Sync command did not start interval");
    AST_IN_SYNC: assert property (@(posedge core_clk) disable iff (!nrst)
        (syn == emd_pkg::EMD_SYN_INPUT && sync_in && !sync_q_r && !cfg_wr) |=> pub_r)
        else $error("Input pulse did not align interval");
    AST_ROLL: assert property (@(posedge core_clk) disable iff (!nrst)
        roll |-> (16'(nbk) * 16'(step) == 16'(ival)))
        else $error("Subintervals do not fill interval");
    AST_PEAK_CLR: assert property (@(posedge core_clk) disable iff (!nrst)
        (pclr_man && !pub_ok) |=> (peak_r == 32'h0 && peak_log_r && log_r == $past(peak_r)))
        else $error("Peak not logged and cleared");
    AST_PEAK_STAMP: assert property (@(posedge core_clk) disable iff (!nrst)
        (pub_ok && dmd_new > peak_r) |=> (peak_r == $past(dmd_new) && ptime_r == $past(rtc_stamp)))
        else $error("Peak or its stamp not captured");
endmodule

// File: rtl/emd_pkg.sv
// Types of the demand block
package emd_pkg;
    typedef enum logic [3:0] {
        EMD_SLIDE, EMD_BLOCK, EMD_ROLL, EMD_IN_BLK, EMD_IN_ROLL,
        EMD_CMD_BLK, EMD_CMD_ROLL, EMD_CLK_BLK, EMD_CLK_ROLL, EMD_THERM
    } emd_mode_t;
    typedef enum logic [1:0] {
        EMD_SYN_TIMER, EMD_SYN_INPUT, EMD_SYN_CMD, EMD_SYN_CLOCK
    } emd_sync_t;
    typedef enum logic [2:0] {
        EMD_SRC_P, EMD_SRC_Q, EMD_SRC_S, EMD_SRC_I, EMD_SRC_UTIL
    } emd_src_t;
endpackage

// File: verif/emd_demand_bench.sv
// Testbench of the demand block
`timescale 1ns/10ps
`include "emd_consts.svh"
// ----------------------------------------
// Bench
// ----------------------------------------
module emd_demand_bench;
    logic        core_clk, nrst, wr_en, rd_en, line_cyc, fire, sync_in, tck;
    logic        dmd_end, refresh, mm_save, peak_log;
    logic [7:0]  addr;
    logic [31:0] wr_data, rd_data;
    logic signed [31:0] samp;
    int          n_fail, num_checks, n_end, n_ref, n_mm, n_log;

    emd_far_end i_emd_far_end (.core_clk(core_clk), .fire(fire), .sync_in(sync_in));
    emd_demand #(.SEC_CYCLES(10)) i_emd_demand (
        .core_clk(core_clk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .samp_p(samp), .samp_q(samp), .samp_s(samp),
        .samp_i(samp), .util_pulse(tck), .line_cyc(line_cyc), .sync_in(sync_in),
        .rtc_min(11'h000), .rtc_min_tick(tck), .rtc_stamp(32'h0000_0000),
        .dmd_end(dmd_end), .refresh(refresh), .mm_save(mm_save), .peak_log(peak_log));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(negedge core_clk) begin
        if (dmd_end === 1'b1) n_end++;
        if (refresh === 1'b1) n_ref++;
        if (mm_save === 1'b1) n_mm++;
        if (peak_log === 1'b1) n_log++;
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 chk($sformatf("reg %h", a), rd_data, e);
    endtask
    task pulses(input int n);
        repeat (n) begin
            @(posedge core_clk) line_cyc <= 1'b1;
            @(posedge core_clk) line_cyc <= 1'b0;
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        nrst = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        line_cyc = 1'b0;
        fire = 1'b0;
        tck = 1'b0;
        addr = 8'h00;
        wr_data = 32'h0;
        samp = 32'sh0;
        n_fail = 0;
        num_checks = 0;
        n_end = 0;
        n_ref = 0;
        n_mm = 0;
        n_log = 0;
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        rdc(`EMD_R_CTRL, `EMD_CTRL_RST);
        rdc(`EMD_R_MIN, `EMD_MIN_RST);
        for (int i = 0; i < 6; i++) begin
            wr(8'h40 + 8'(8 * i), 32'hffff_ffff);
            wr(8'h44 + 8'(8 * i), 32'hffff_ffff);
            rdc(8'h44 + 8'(8 * i), 32'h7fff_ffff);
            rdc(8'h40 + 8'(8 * i), 32'hffff_ffff);
            wr(8'h40 + 8'(8 * i), 32'(i));
            wr(8'h44 + 8'(8 * i), 32'(i + 16));
            rdc(8'h44 + 8'(8 * i), 32'(i + 16));
        end
        rdc(8'h70, 32'h0000_0000);
        $display("preset test done");
        pulses(100);
        @(posedge core_clk);
        chk("refresh 50", 32'(n_ref), 32'h2);
        wr(`EMD_R_CTRL, `EMD_CTRL_RST | 32'h1000_0000);
        n_ref = 0;
        pulses(120);
        @(posedge core_clk);
        chk("refresh 60", 32'(n_ref), 32'h2);
        chk("min max save", 32'(n_mm), 32'h1);
        rdc(`EMD_R_MIN, 32'h0000_0000);
        rdc(`EMD_R_MAX, 32'h0000_0000);
        $display("refresh test done");
        samp <= 32'sh64;
        wr(`EMD_R_CTRL, 32'h0005_0f05);
        n_end = 0;
        repeat (30) @(posedge core_clk);
        wr(`EMD_R_CMD, 32'h0000_0001);
        repeat (3) @(posedge core_clk);
        chk("cmd sync", 32'(n_end), 32'h1);
        rdc(`EMD_R_CMD, 32'h0000_0000);
        rdc(`EMD_R_LAST, 32'h0000_0064);
        rdc(`EMD_R_PEAK, 32'h0000_0064);
        wr(`EMD_R_CMD, 32'h0000_0002);
        rdc(`EMD_R_LOG, 32'h0000_0064);
        rdc(`EMD_R_PEAK, 32'h0000_0000);
        chk("peak log", 32'(n_log), 32'h1);
        $display("peak test done");
        wr(`EMD_R_CTRL, 32'h0005_0f03);
        n_end = 0;
        @(posedge core_clk) fire <= 1'b1;
        @(posedge core_clk) fire <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk("input sync", 32'(n_end), 32'h1);
        $display("sync test done");
        give_verdict;
    end
    initial begin
        #(20 * 10000);
        n_fail++;
        give_verdict;
    end
endmodule

// File: verif/emd_far_end.sv
// Far-side model: external sync pulse source
`timescale 1ns/10ps
// ----------------------------------------
// Pulse source
// ----------------------------------------
module emd_far_end (
    input  wire logic core_clk,
    input  wire logic fire,
    output logic      sync_in
);
    initial sync_in = 1'b0;
    always @(posedge core_clk) begin
        sync_in <= fire;
    end
endmodule
